// [core/frame_pkg.sv]
// Purpose: Shared constants and types for the command frame handler.
// Assumes: Byte-wide link, one frame in flight at a time.
// Notes: Frame positions are byte slots of the nine-byte serial frame.
//
// Notes on behaviour
// - Host starts every exchange; the block answers each command exactly once.
// - A bad checksum is answered at once; other replies go out only after the executor reports the command finished.
// - Nothing is transmitted unless a command frame was received first.
// - Transmitter stays released and receiving except while sending a reply.
// - Command core is code, type, motor/bank byte and a four-byte value.
// - Serial frames add a leading address and trailing checksum: nine bytes.
// - Order is address, code, type, bank, value MSB first, checksum.
// - Checksum is the 8-bit wrapping sum of the eight bytes before it.
// - Every received command gets a reply on the same link.
// - Reply order is host address, module address, status, code, value, checksum.
// - Reply checksum is the 8-bit wrapping sum of the eight reply bytes.
// - Status 100 means executed, 101 means stored into program memory.
// - Error codes 1 checksum, 2 command, 3 type, 4 value, 5 locked, 6 unavailable.
// - CAN commands drop address and checksum; identifier gives the address.
// - CAN replies drop the host address and checksum but keep the module address byte.
package frame_pkg;
    localparam int BYTE_W = 8;
    localparam int VALUE_W = 32;
    localparam int VALUE_BYTES = 4;
    localparam int SERIAL_LEN = 9;
    localparam int REPLY_FIFO_DEPTH = 16;

    typedef logic [3:0] idx_t;
    typedef logic [BYTE_W-1:0] byte_t;

    // ------------------------------------------------------------
    // Command frame slots
    // ------------------------------------------------------------
    localparam idx_t ADDR_IDX = 4'h0;
    localparam idx_t CMD_IDX = 4'h1;
    localparam idx_t TYPE_IDX = 4'h2;
    localparam idx_t BANK_IDX = 4'h3;
    localparam idx_t VAL_IDX = 4'h4;
    localparam idx_t SUM_IDX = 4'h8;
    localparam idx_t CAN_FIRST_IDX = 4'h1;

    // ------------------------------------------------------------
    // Reply frame slots
    // ------------------------------------------------------------
    localparam idx_t R_HOST_IDX = 4'h0;
    localparam idx_t R_MOD_IDX = 4'h1;
    localparam idx_t R_STAT_IDX = 4'h2;
    localparam idx_t R_CMD_IDX = 4'h3;
    localparam idx_t R_VAL0_IDX = 4'h4;
    localparam idx_t R_VAL1_IDX = 4'h5;
    localparam idx_t R_VAL2_IDX = 4'h6;
    localparam idx_t R_VAL3_IDX = 4'h7;
    localparam idx_t R_SUM_IDX = 4'h8;

    // Index of the last byte counted from zero
    localparam idx_t LAST_CNT_SERIAL = 4'h8;
    localparam idx_t LAST_CNT_CAN = 4'h6;

    // ------------------------------------------------------------
    // Status codes
    // ------------------------------------------------------------
    localparam byte_t STATUS_OK = 8'h64;
    localparam byte_t STATUS_STORED = 8'h65;
    localparam byte_t STATUS_BAD_SUM = 8'h01;
    localparam byte_t STATUS_BAD_CMD = 8'h02;
    localparam byte_t STATUS_BAD_TYPE = 8'h03;
    localparam byte_t STATUS_BAD_VALUE = 8'h04;
    localparam byte_t STATUS_LOCKED = 8'h05;
    localparam byte_t STATUS_NO_CMD = 8'h06;

    typedef enum logic [1:0] {
        ST_RECV = 2'b00,
        ST_EXEC = 2'b01,
        ST_REPLY = 2'b11,
        ST_DRAIN = 2'b10
    } state_t;
endpackage : frame_pkg

// [core/byte_stream_if.sv]
// Purpose: Valid/ready byte stream between the handler and its reply FIFO.
// Assumes: Transfer when valid and ready are both high at a clock edge.
// Notes: Source holds data stable while valid is high and ready low.
interface byte_stream_if #(
    parameter int WIDTH = 8
) ();
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;

    modport source (output data, output valid, input ready);
    modport sink (input data, input valid, output ready);
endinterface : byte_stream_if

// [core/reply_fifo.sv]
// Purpose: Flip-flop FIFO for reply bytes with valid/ready on both sides.
// Assumes: DEPTH is a power of two, at least two.
// Notes: Output data comes straight from the storage flops.
module reply_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    byte_stream_if.sink fillPort,
    byte_stream_if.source drainPort
);
    import frame_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
        $error("reply_fifo DEPTH must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W:0] wrPtr_q;
    logic [PTR_W:0] rdPtr_q;

    wire logic empty = (wrPtr_q == rdPtr_q);
    wire logic full = (wrPtr_q[PTR_W-1:0] == rdPtr_q[PTR_W-1:0]) && (wrPtr_q[PTR_W] != rdPtr_q[PTR_W]);
    wire logic push = fillPort.valid && !full;
    wire logic pop = drainPort.ready && !empty;

    assign fillPort.ready = !full;
    assign drainPort.valid = !empty;
    assign drainPort.data = mem_q[rdPtr_q[PTR_W-1:0]];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + (PTR_W+1)'(push);
            rdPtr_q <= rdPtr_q + (PTR_W+1)'(pop);
        end
    end

    // No reset on storage; nothing reads a slot before it is written
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wrPtr_q[PTR_W-1:0]] <= fillPort.data;
        end
    end
endmodule : reply_fifo

// [core/serial_command_frame_handler.sv]
// Purpose: Parse host command frames, hand commands to the executor, format replies.
// Assumes: Byte receiver and transmitter outside; canMode static between frames.
// Notes: One frame in flight; bytes arriving outside reception are dropped.
module serial_command_frame_handler #(
    parameter int FIFO_DEPTH = frame_pkg::REPLY_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic canMode,
    input wire frame_pkg::byte_t moduleAddr,
    input wire frame_pkg::byte_t hostAddr,
    input wire frame_pkg::byte_t rxData,
    input wire logic rxValid,
    input wire logic rxResync,
    output logic cmdValid,
    output frame_pkg::byte_t cmdCode,
    output frame_pkg::byte_t cmdType,
    output frame_pkg::byte_t cmdBank,
    output logic [frame_pkg::VALUE_W-1:0] cmdValue,
    input wire logic execDone,
    input wire frame_pkg::byte_t execStatus,
    input wire logic [frame_pkg::VALUE_W-1:0] execValue,
    output frame_pkg::byte_t txData,
    output logic txValid,
    input wire logic txReady,
    input wire logic txBusy,
    output logic txEnable
);
    import frame_pkg::*;

    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("FIFO_DEPTH must be at least two");
    end

    // ------------------------------------------------------------
    // Reply byte selection
    // ------------------------------------------------------------
    function automatic byte_t replyByte(
        input idx_t pos,
        input byte_t host,
        input byte_t modA,
        input byte_t stat,
        input byte_t code,
        input logic [VALUE_W-1:0] val,
        input byte_t sum
    );
        byte_t b;
        b = 8'h00;
        case (pos)
            R_HOST_IDX: b = host;
            R_MOD_IDX: b = modA;
            R_STAT_IDX: b = stat;
            R_CMD_IDX: b = code;
            R_VAL0_IDX: b = val[31:24];
            R_VAL1_IDX: b = val[23:16];
            R_VAL2_IDX: b = val[15:8];
            R_VAL3_IDX: b = val[7:0];
            R_SUM_IDX: b = sum;
            default: b = 8'h00;
        endcase
        return b;
    endfunction : replyByte

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    state_t state_q;
    state_t state_d;
    byte_t frame_q [SERIAL_LEN];
    idx_t rxCnt_q;
    idx_t rxCnt_d;
    byte_t rxSum_q;
    byte_t rxSum_d;
    idx_t txCnt_q;
    idx_t txCnt_d;
    byte_t txSum_q;
    byte_t txSum_d;
    byte_t status_q;
    logic [VALUE_W-1:0] value_q;
    logic cmdValid_q;
    logic txPopped_q;

    byte_stream_if #(.WIDTH(BYTE_W)) replyIf ();
    byte_stream_if #(.WIDTH(BYTE_W)) txIf ();

    // ------------------------------------------------------------
    // Receive decoding
    // ------------------------------------------------------------
    // CAN frames start one slot in, so both modes share the slot map
    wire idx_t firstIdx = canMode ? CAN_FIRST_IDX : ADDR_IDX;
    wire idx_t lastCnt = canMode ? LAST_CNT_CAN : LAST_CNT_SERIAL;
    wire idx_t rxPos = rxCnt_q + firstIdx;
    wire logic rxTake = rxValid && (state_q == ST_RECV);
    wire logic rxLastByte = rxTake && (rxCnt_q == lastCnt);
    wire logic addrOk = canMode || (frame_q[ADDR_IDX] == moduleAddr);
    wire logic sumOk = canMode || (rxData == rxSum_q);
    wire logic frameGood = rxLastByte && addrOk && sumOk;
    wire logic frameBadSum = rxLastByte && addrOk && !sumOk;

    // Index is a running count; a lost byte shifts framing until resync
    always_comb begin
        rxCnt_d = rxCnt_q;
        rxSum_d = rxSum_q;
        if (rxResync || rxLastByte) begin
            rxCnt_d = '0;
            rxSum_d = '0;
        end else if (rxTake) begin
            rxCnt_d = rxCnt_q + 4'h1;
            rxSum_d = rxSum_q + rxData;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxCnt_q <= '0;
            rxSum_q <= '0;
        end else begin
            rxCnt_q <= rxCnt_d;
            rxSum_q <= rxSum_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < SERIAL_LEN; i++) begin
                frame_q[i] <= 8'h00;
            end
        end else if (rxTake) begin
            frame_q[rxPos] <= rxData;
        end
    end

    // ------------------------------------------------------------
    // Command fields
    // ------------------------------------------------------------
    assign cmdCode = frame_q[CMD_IDX];
    assign cmdType = frame_q[TYPE_IDX];
    assign cmdBank = frame_q[BANK_IDX];
    assign cmdValid = cmdValid_q;

    for (genvar i = 0; i < VALUE_BYTES; i++) begin : g_value
        // Most significant byte arrives first
        assign cmdValue[VALUE_W-1-BYTE_W*i -: BYTE_W] = frame_q[VAL_IDX + idx_t'(i)];
    end

    // ------------------------------------------------------------
    // Control sequence
    // ------------------------------------------------------------
    wire logic replyPush = replyIf.valid && replyIf.ready;
    wire logic pushLast = replyPush && (txCnt_q == lastCnt);
    // Wait one cycle after the last hand-off so txBusy has time to rise
    wire logic lineIdle = !txIf.valid && !txBusy && !txPopped_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RECV: begin
                if (frameGood) begin
                    state_d = ST_EXEC;
                end else if (frameBadSum) begin
                    state_d = ST_REPLY;
                end
            end
            ST_EXEC: begin
                if (execDone) begin
                    state_d = ST_REPLY;
                end
            end
            ST_REPLY: begin
                if (pushLast) begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (lineIdle) begin
                    state_d = ST_RECV;
                end
            end
            default: state_d = ST_RECV;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_RECV;
            cmdValid_q <= 1'b0;
            txPopped_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmdValid_q <= frameGood;
            txPopped_q <= txIf.valid && txIf.ready;
        end
    end

    // Status and value come from the executor, except a bad checksum, which never reaches it and loads status 1 with value 0
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= 8'h00;
            value_q <= '0;
        end else if (frameBadSum) begin
            status_q <= STATUS_BAD_SUM;
            value_q <= '0;
        end else if (state_q == ST_EXEC && execDone) begin
            status_q <= execStatus;
            value_q <= execValue;
        end
    end

    // ------------------------------------------------------------
    // Reply formatting
    // ------------------------------------------------------------
    wire idx_t txPos = txCnt_q + firstIdx;

    always_comb begin
        txCnt_d = txCnt_q;
        txSum_d = txSum_q;
        if (state_q != ST_REPLY) begin
            txCnt_d = '0;
            txSum_d = '0;
        end else if (replyPush) begin
            txCnt_d = txCnt_q + 4'h1;
            txSum_d = txSum_q + replyIf.data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txCnt_q <= '0;
            txSum_q <= '0;
        end else begin
            txCnt_q <= txCnt_d;
            txSum_q <= txSum_d;
        end
    end

    // Bytes enter the FIFO only while a reply is owed
    assign replyIf.valid = (state_q == ST_REPLY);
    assign replyIf.data = replyByte(txPos, hostAddr, moduleAddr, status_q, frame_q[CMD_IDX], value_q,
                                    txSum_q);

    reply_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_reply_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .fillPort(replyIf.sink),
        .drainPort(txIf.source)
    );

    assign txData = txIf.data;
    assign txValid = txIf.valid;
    assign txIf.ready = txReady;
    // Driver enabled only from first reply byte until the line is idle
    assign txEnable = (state_q == ST_REPLY) || (state_q == ST_DRAIN);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    byte_t expSum;
    idx_t sentCnt_q;
    assign expSum = hostAddr + moduleAddr + status_q + frame_q[CMD_IDX] + value_q[31:24] + value_q[23:16]
                    + value_q[15:8] + value_q[7:0];

    // Counts bytes that actually left the FIFO, not bytes pushed into it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sentCnt_q <= '0;
        end else if (state_q == ST_RECV) begin
            sentCnt_q <= '0;
        end else if (txIf.valid && txIf.ready) begin
            sentCnt_q <= sentCnt_q + 4'h1;
        end
    end

    sequence acceptedFrame;
        rxLastByte && addrOk && sumOk;
    endsequence

    sequence cmdPulse;
        cmdValid ##1 !cmdValid;
    endsequence

    sequence replyOpens;
        $rose(state_q == ST_REPLY);
    endsequence

    tx_after_cmd_a: assert property ($rose(txEnable) |-> $past(state_q) == ST_EXEC || $past(frameBadSum))
        else $error("transmitter enabled without a received command");

    idle_release_a: assert property ((state_q == ST_RECV) |-> !txEnable && !txValid)
        else $error("transmitter active while receiving");

    exec_wait_a: assert property ((state_q == ST_EXEC && !execDone) |=> !replyIf.valid && txCnt_q == 4'h0)
        else $error("reply started before execution finished");

    good_frame_a: assert property (acceptedFrame |=> (state_q == ST_EXEC) ##0 cmdPulse)
        else $error("valid frame did not issue one command pulse");

    bad_sum_a: assert property (frameBadSum |=> !cmdValid && state_q == ST_REPLY
                                && status_q == STATUS_BAD_SUM)
        else $error("bad checksum frame not answered with status 1");

    foreign_addr_a: assert property ((rxLastByte && !addrOk) |=> state_q == ST_RECV && !cmdValid [*2])
        else $error("frame for another address was acted on");

    reply_head_a: assert property (replyOpens |-> replyIf.data == (canMode ? moduleAddr : hostAddr))
        else $error("reply does not open with the expected address byte");

    reply_sum_a: assert property ((replyPush && txPos == R_SUM_IDX) |-> replyIf.data == expSum)
        else $error("reply checksum mismatch");

    reply_len_a: assert property ((state_q == ST_DRAIN && lineIdle) |-> sentCnt_q == idx_t'(lastCnt + 4'h1))
        else $error("reply length differs from one full frame");

    status_echo_a: assert property ((state_q == ST_EXEC && execDone) |=> status_q == $past(execStatus))
        else $error("reply status differs from executor status");
endmodule : serial_command_frame_handler

// [testbench/host_link_model.sv]
// Purpose: Transmitter and host side of the byte link, collecting reply bytes.
// Assumes: One byte accepted at a time; shifting takes one or six cycles.
// Notes: Reply bytes are kept in got for the bench to compare.
module host_link_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire frame_pkg::byte_t txData,
    input wire logic txValid,
    input wire logic txEnable,
    output logic txReady,
    output logic txBusy
);
    import frame_pkg::*;
    byte_t got[$];
    int strayCount = 0;
    int shiftLeft;

    // ----------------------------------------
    // Accept, then hold busy while shifting
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txReady <= 1'b1;
            txBusy <= 1'b0;
            shiftLeft <= 0;
        end else if (txValid && txReady) begin
            got.push_back(txData);
            // A byte without the driver enabled would collide on a shared bus
            if (txEnable !== 1'b1) strayCount++;
            txReady <= 1'b0;
            txBusy <= 1'b1;
            shiftLeft <= slow ? 6 : 1;
        end else if (shiftLeft > 1) begin
            shiftLeft <= shiftLeft - 1;
        end else if (txBusy) begin
            txBusy <= 1'b0;
            txReady <= 1'b1;
            shiftLeft <= 0;
        end
    end
endmodule : host_link_model

// [testbench/test_serial_command_frame_handler.sv]
// Purpose: Self-checking bench for the command frame handler.
// Assumes: Executor is played by the bench; host link by host_link_model.
// Notes: Inputs change at rising edges, outputs are sampled at falling edges.
module test_serial_command_frame_handler;
    timeunit 1ns;
    timeprecision 1ps;
    import frame_pkg::*;
    typedef byte_t bq_t[$];

    logic clk = 1'b0;
    logic reset_n, canMode, slow, rxValid, rxResync, execDone;
    byte_t moduleAddr, hostAddr, rxData, execStatus, cmdCode, cmdType, cmdBank, txData;
    logic [31:0] execValue, cmdValue;
    logic cmdValid, txValid, txReady, txBusy, txEnable;
    int failCount = 0;
    int nTests = 0;

    always #2.5 clk = ~clk;

    serial_command_frame_handler #(.FIFO_DEPTH(16)) uut (
        .clk(clk), .reset_n(reset_n), .canMode(canMode), .moduleAddr(moduleAddr),
        .hostAddr(hostAddr), .rxData(rxData), .rxValid(rxValid), .rxResync(rxResync),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdType(cmdType), .cmdBank(cmdBank),
        .cmdValue(cmdValue), .execDone(execDone), .execStatus(execStatus),
        .execValue(execValue), .txData(txData), .txValid(txValid), .txReady(txReady),
        .txBusy(txBusy), .txEnable(txEnable)
    );

    host_link_model partner (
        .clk(clk), .reset_n(reset_n), .slow(slow), .txData(txData), .txValid(txValid),
        .txEnable(txEnable), .txReady(txReady), .txBusy(txBusy)
    );

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic checkVal(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : checkVal

    task automatic giveVerdict;
        if (failCount == 0 && nTests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : giveVerdict

    // Serial frame with wrapping sum; CAN strips address and sum
    function automatic bq_t frameOf(byte_t a, byte_t b, byte_t c, byte_t d, logic [31:0] v,
                                    logic can, logic badSum);
        bq_t f;
        byte_t s;
        f = {a, b, c, d, v[31:24], v[23:16], v[15:8], v[7:0]};
        s = 8'h00;
        foreach (f[i]) s += f[i];
        f.push_back(badSum ? s + 8'h01 : s);
        if (can) begin
            f.pop_back();
            f.pop_front();
        end
        return f;
    endfunction : frameOf

    task automatic sendBytes(input bq_t b);
        foreach (b[i]) begin
            @(posedge clk);
            rxValid <= 1'b1;
            rxData <= b[i];
        end
        @(posedge clk);
        rxValid <= 1'b0;
        rxData <= ~rxData;
    endtask : sendBytes

    task automatic waitReply(input int base, input bq_t exp);
        int k;
        @(negedge clk);
        for (k = 0; k < 20 && txEnable !== 1'b1; k++) @(negedge clk);
        checkVal(txEnable, 1'b1);
        for (k = 0; k < 400 && txEnable !== 1'b0; k++) @(negedge clk);
        checkVal(txEnable, 1'b0);
        checkVal(partner.got.size() - base, exp.size());
        foreach (exp[i]) checkVal(partner.got[base + i], exp[i]);
    endtask : waitReply

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic runCmd(input logic can, input byte_t c, input byte_t t, input byte_t bk,
                          input logic [31:0] v, input byte_t st, input logic [31:0] rv, input logic junk);
        int base;
        base = partner.got.size();
        @(posedge clk);
        canMode <= can;
        sendBytes(frameOf(moduleAddr, c, t, bk, v, can, 1'b0));
        @(negedge clk);
        checkVal(cmdValid, 1'b1);
        checkVal({cmdCode, cmdType, cmdBank}, {c, t, bk});
        checkVal(cmdValue, v);
        // Bytes arriving while the command runs must be dropped
        repeat (4) begin
            @(posedge clk);
            rxValid <= junk;
            rxData <= moduleAddr;
            @(negedge clk);
            checkVal({txEnable, txValid, cmdValid}, 3'b000);
        end
        @(posedge clk);
        rxValid <= 1'b0;
        execDone <= 1'b1;
        execStatus <= st;
        execValue <= rv;
        @(posedge clk);
        execDone <= 1'b0;
        execStatus <= ~st;
        execValue <= ~rv;
        waitReply(base, frameOf(hostAddr, moduleAddr, st, c, rv, can, 1'b0));
    endtask : runCmd

    task automatic testBadSum;
        int base;
        base = partner.got.size();
        sendBytes(frameOf(moduleAddr, 8'h06, 8'h01, 8'h00, 32'h1234_5678, 1'b0, 1'b1));
        @(negedge clk);
        checkVal(cmdValid, 1'b0);
        waitReply(base, frameOf(hostAddr, moduleAddr, STATUS_BAD_SUM, 8'h06, 32'h0, 1'b0, 1'b0));
    endtask : testBadSum

    task automatic testOtherAddr;
        int base;
        logic seen;
        base = partner.got.size();
        seen = 1'b0;
        sendBytes(frameOf(moduleAddr + 8'h01, 8'h05, 8'h00, 8'h00, 32'h0, 1'b0, 1'b0));
        sendBytes(frameOf(moduleAddr + 8'h02, 8'h05, 8'h00, 8'h00, 32'h0, 1'b0, 1'b1));
        @(posedge clk);
        execDone <= 1'b1;
        @(posedge clk);
        execDone <= 1'b0;
        repeat (30) begin
            @(negedge clk);
            seen = seen | txEnable | txValid | cmdValid;
        end
        checkVal(seen, 1'b0);
        checkVal(partner.got.size() - base, 0);
    endtask : testOtherAddr

    task automatic testResync;
        bq_t f;
        f = frameOf(moduleAddr, 8'h01, 8'h02, 8'h03, 32'h0, 1'b0, 1'b0);
        f = f[0:4];
        sendBytes(f);
        @(posedge clk);
        rxResync <= 1'b1;
        @(posedge clk);
        rxResync <= 1'b0;
        runCmd(1'b0, 8'h0f, 8'h00, 8'h01, 32'h0000_00ff, STATUS_OK, 32'h7fff_ffff, 1'b0);
    endtask : testResync

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        byte_t codes[7];
        codes = '{STATUS_OK, STATUS_STORED, STATUS_BAD_CMD, STATUS_BAD_TYPE, STATUS_BAD_VALUE,
                  STATUS_LOCKED, STATUS_NO_CMD};
        reset_n = 1'b0;
        canMode = 1'b0;
        slow = 1'b0;
        moduleAddr = 8'h03;
        hostAddr = 8'h02;
        rxData = 8'h00;
        rxValid = 1'b0;
        rxResync = 1'b0;
        execDone = 1'b0;
        execStatus = 8'h00;
        execValue = 32'h0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        checkVal({cmdValid, txValid, txEnable}, 3'b000);
        runCmd(1'b0, 8'h04, 8'h00, 8'h00, 32'h8001_fe7f, STATUS_OK, 32'hfffe_0c18, 1'b0);
        foreach (codes[i]) begin
            @(posedge clk);
            slow <= (i % 2 == 1);
            runCmd(1'b0, byte_t'(8'h10 + i), 8'hf0, 8'h01, 32'h0102_0304 << i, codes[i], ~(32'h0a0b << i),
                   (i == 2));
        end
        testBadSum();
        testOtherAddr();
        testResync();
        runCmd(1'b1, 8'h07, 8'h00, 8'h00, 32'hdead_0001, STATUS_OK, 32'h00c0_ffee, 1'b0);
        runCmd(1'b1, 8'h22, 8'h09, 8'h02, 32'hffff_ffff, STATUS_BAD_TYPE, 32'h1, 1'b1);
        runCmd(1'b0, 8'h03, 8'h00, 8'h00, 32'h0, STATUS_OK, 32'h0, 1'b0);
        checkVal(partner.strayCount, 0);
        giveVerdict();
    end

    // Whole run is under a thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        giveVerdict();
    end
endmodule : test_serial_command_frame_handler
